// >>> include/tmr_pkg.sv
package tmr_pkg;

	// Byte addresses of the register window (APB, one word each)
	localparam logic [7:0] ADDR_COUNT    = 8'h00;
	localparam logic [7:0] ADDR_GRA      = 8'h04;
	localparam logic [7:0] ADDR_GRB      = 8'h08;
	localparam logic [7:0] ADDR_BUFA     = 8'h0C;
	localparam logic [7:0] ADDR_CTRL     = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
	localparam logic [7:0] ADDR_SYNC_CNT = 8'h1C;
	localparam logic [7:0] ADDR_PRIO     = 8'h20;

	// Control register fields
	localparam int CTRL_RUN       = 0;
	localparam int CTRL_PWM       = 1;
	localparam int CTRL_CAP_A     = 2;
	localparam int CTRL_CLR_LO    = 3;
	localparam int CTRL_CLR_HI    = 4;
	localparam int CTRL_SYNC      = 5;
	localparam int CTRL_BUF_A     = 6;
	localparam int CTRL_PAIR_LO   = 7;
	localparam int CTRL_PAIR_HI   = 8;
	localparam int CTRL_XTRG_DIS  = 9;
	localparam int CTRL_WIDTH     = 10;

	// Status / enable fields
	localparam int ST_MATCH_A = 0;
	localparam int ST_MATCH_B = 1;
	localparam int ST_WRAP    = 2;
	localparam int ST_OUT_OFF = 3;
	localparam int ST_WIDTH   = 4;

	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] GR_RST    = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RST = 10'h000;
	localparam logic [7:0] PRIO_RST   = 8'h00;

	// Bus cycle states: setup precedes the first, access wait the second,
	// the completing access the third
	typedef enum logic [1:0] {BUS_IDLE, BUS_T1, BUS_T2, BUS_T3} bus_state_t;

	// Three-state cycle: one wait cycle inserted before pready
	localparam int BUS_WAIT = 1;

endpackage

// >>> logic/bus_phase.sv
`timescale 1ns/1ns
module bus_phase import tmr_pkg::*; (
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic clk_en_in,
	input  wire logic psel_in,
	input  wire logic penable_in,
	output bus_state_t state_out,
	output logic       ready_out
);
	bus_state_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			BUS_IDLE: if (psel_in) st_nxt = BUS_T1;
			BUS_T1: st_nxt = BUS_T2;
			BUS_T2: st_nxt = BUS_T3;
			BUS_T3: st_nxt = (psel_in && !penable_in) ? BUS_T1 :
				(psel_in ? BUS_T3 : BUS_IDLE);
			default: st_nxt = BUS_IDLE;
		endcase
		if (st_r == BUS_T3 && psel_in && penable_in)
			st_nxt = BUS_IDLE;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			st_r <= BUS_IDLE;
		else if (clk_en_in)
			st_r <= st_nxt;
	end

	assign state_out = st_r;
	assign ready_out = (st_r == BUS_T3);
endmodule

// >>> logic/count_core.sv
`timescale 1ns/1ns
module count_core import tmr_pkg::*; (
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        clk_en_in,
	input  wire logic        clear_in,
	input  wire logic        inc_in,
	input  wire logic        load_in,
	input  wire logic [15:0] load_val_in,
	output logic [15:0]      count_out,
	output logic             wrap_out
);
	logic [15:0] cnt_r;
	wire         cnt_step;

	// Clear beats write, write beats increment
	assign cnt_step = inc_in && !clear_in && !load_in;
	assign wrap_out = inc_in && !clear_in && (cnt_r == COUNT_MAX);

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cnt_r <= COUNT_RST;
		else if (clk_en_in) begin
			if (clear_in)
				cnt_r <= COUNT_RST;
			else if (load_in)
				cnt_r <= load_val_in;
			else if (cnt_step)
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	assign count_out = cnt_r;
endmodule

// >>> logic/timer_channel_contention_logic.sv
`timescale 1ns/1ns
// Behaviour
// - Clear beats counter write in third state
// - Word write beats increment in third state
// - Byte write beats increment, other byte kept
// - Register write suppresses coincident compare match
// - Write wins over wrap, wrap flag set
// - Register read returns value before capture
// - Capture clear beats increment, old count captured
// - Capture beats register write
// - Match clear gives period N plus one
// - Capture transfer beats buffer write
// - Byte write loads whole value into synced
// - No input capture in PWM mode
// - Simultaneous matches A and B suppressed in PWM mode
// - Output disable only on input capture in paired mode, PWM off
// - Priority register resets to zero; it is read back but orders nothing
// - Wrap flag set on rollover
// - Flag cleared by read one, write zero
// - Match asserted at last equal state
// - Interrupt only when flag and enable
module timer_channel_contention_logic import tmr_pkg::*; (
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        clk_en_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	input  wire logic        tick_in,
	input  wire logic        capture_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic [ST_WIDTH-2:0] irq_out,
	output logic             out_enable_out,
	output logic [15:0]      count_out
);
	bus_state_t  bstate;
	logic        bus_rdy;
	logic [15:0] cnt, sync_cnt_r;
	logic        wrap;
	logic [15:0] gra_r, grb_r, bufa_r;
	logic [CTRL_WIDTH-1:0] ctrl_r;
	logic [ST_WIDTH-1:0] stat_r, stat_nxt, ien_r, seen_r;
	logic [7:0]  prio_r;
	logic [15:0] rd_snap_r;
	logic        oe_r;
	logic        match_a_prev_r, match_b_prev_r;

	bus_phase u_phase (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.clk_en_in   (clk_en_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.state_out   (bstate),
		.ready_out   (bus_rdy)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	wire t3     = bus_rdy && psel_in && penable_in;
	wire t2     = (bstate == BUS_T2);
	wire wr_t3  = t3 && pwrite_in;
	wire rd_t3  = t3 && !pwrite_in;
	wire wr_cnt = wr_t3 && hit(paddr_in, ADDR_COUNT);
	wire wr_gra = wr_t3 && hit(paddr_in, ADDR_GRA);
	wire wr_grb = wr_t3 && hit(paddr_in, ADDR_GRB);
	wire wr_buf = wr_t3 && hit(paddr_in, ADDR_BUFA);
	wire byte_w = (pstrb_in[1:0] != 2'b11);
	wire byte_acc = psel_in && pwrite_in && hit(paddr_in, ADDR_COUNT) &&
		byte_w && (t2 || t3);
	wire [15:0] wr_val = {pstrb_in[1] ? pwdata_in[15:8] : cnt[15:8],
		pstrb_in[0] ? pwdata_in[7:0] : cnt[7:0]};

	wire run     = ctrl_r[CTRL_RUN];
	wire pwm     = ctrl_r[CTRL_PWM];
	wire [1:0] clr_sel = {ctrl_r[CTRL_CLR_HI], ctrl_r[CTRL_CLR_LO]};
	wire paired  = ctrl_r[CTRL_PAIR_HI];
	wire cap_ok  = capture_in && ctrl_r[CTRL_CAP_A] && !pwm;
	wire inc     = tick_in && run && !(byte_acc && t2);
	wire eq_a    = (cnt == gra_r);
	wire eq_b    = (cnt == grb_r);
	// Match fires in the last equal state, as the count moves on
	wire raw_a   = eq_a && inc && !cap_ok;
	wire raw_b   = eq_b && inc;
	wire both    = pwm && raw_a && raw_b;
	wire match_a = raw_a && !both && !wr_gra;
	wire match_b = raw_b && !both && !wr_grb;
	wire clear   = (clr_sel == 2'b01 && (match_a || cap_ok)) ||
		(clr_sel == 2'b10 && match_b);
	wire load    = wr_cnt || (byte_acc && t2 && tick_in);
	wire [15:0] ld_v = wr_val;

	count_core u_count (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.clk_en_in   (clk_en_in),
		.clear_in    (clear),
		.inc_in      (inc),
		.load_in     (load && !(byte_acc && t2 && !wr_cnt)),
		.load_val_in (ld_v),
		.count_out   (cnt),
		.wrap_out    (wrap)
	);

	// Flags: set wins over clear; clear needs a prior read of one
	always_comb begin
		stat_nxt = stat_r;
		if (wr_t3 && hit(paddr_in, ADDR_STATUS))
			stat_nxt = stat_r & (pwdata_in[ST_WIDTH-1:0] | ~seen_r);
		if (match_a || cap_ok)
			stat_nxt[ST_MATCH_A] = 1'b1;
		if (match_b)
			stat_nxt[ST_MATCH_B] = 1'b1;
		if (wrap)
			stat_nxt[ST_WRAP] = 1'b1;
		if (cap_ok && paired && !ctrl_r[CTRL_XTRG_DIS])
			stat_nxt[ST_OUT_OFF] = 1'b1;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			gra_r  <= GR_RST;
			grb_r  <= GR_RST;
			bufa_r <= GR_RST;
		end else if (clk_en_in) begin
			if (cap_ok) begin
				gra_r <= cnt;
				if (ctrl_r[CTRL_BUF_A])
					bufa_r <= gra_r;
			end else if (wr_gra)
				gra_r <= pwdata_in[15:0];
			if (wr_grb)
				grb_r <= pwdata_in[15:0];
			if (wr_buf && !(cap_ok && ctrl_r[CTRL_BUF_A]))
				bufa_r <= pwdata_in[15:0];
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_r <= CTRL_RST;
			ien_r  <= '0;
			stat_r <= '0;
			seen_r <= '0;
			prio_r <= PRIO_RST;
			sync_cnt_r <= COUNT_RST;
		end else if (clk_en_in) begin
			stat_r <= stat_nxt;
			if (wr_t3 && hit(paddr_in, ADDR_CTRL))
				ctrl_r <= pwdata_in[CTRL_WIDTH-1:0];
			if (wr_t3 && hit(paddr_in, ADDR_IRQ_EN))
				ien_r <= pwdata_in[ST_WIDTH-1:0];
			if (wr_t3 && hit(paddr_in, ADDR_PRIO))
				prio_r <= pwdata_in[7:0];
			if (rd_t3 && hit(paddr_in, ADDR_STATUS))
				seen_r <= stat_r;
			else if (wr_t3 && hit(paddr_in, ADDR_STATUS))
				seen_r <= '0;
			if (wr_cnt && ctrl_r[CTRL_SYNC] && !clear)
				sync_cnt_r <= wr_val;
			else if (ctrl_r[CTRL_SYNC] && clear)
				sync_cnt_r <= COUNT_RST;
		end
	end

	// Read data comes from values held before this edge
	logic [31:0] rd_mux;
	always_comb begin
		case (paddr_in)
			ADDR_COUNT:    rd_mux = {16'h0000, cnt};
			ADDR_GRA:      rd_mux = {16'h0000, gra_r};
			ADDR_GRB:      rd_mux = {16'h0000, grb_r};
			ADDR_BUFA:     rd_mux = {16'h0000, bufa_r};
			ADDR_CTRL:     rd_mux = {22'h000000, ctrl_r};
			ADDR_STATUS:   rd_mux = {28'h0000000, stat_r};
			ADDR_IRQ_EN:   rd_mux = {28'h0000000, ien_r};
			ADDR_SYNC_CNT: rd_mux = {16'h0000, sync_cnt_r};
			ADDR_PRIO:     rd_mux = {24'h000000, prio_r};
			default:       rd_mux = 32'h00000000;
		endcase
	end
	wire unmapped = (paddr_in > ADDR_PRIO) || (paddr_in[1:0] != 2'b00);

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prdata_out  <= 32'h00000000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			irq_out     <= '0;
			oe_r        <= 1'b1;
		end else if (clk_en_in) begin
			pready_out  <= (bstate == BUS_T2) && psel_in;
			pslverr_out <= (bstate == BUS_T2) && psel_in && unmapped;
			prdata_out  <= rd_mux;
			irq_out     <= stat_nxt[ST_WIDTH-2:0] & ien_r[ST_WIDTH-2:0];
			oe_r        <= !stat_nxt[ST_OUT_OFF];
		end
	end

	assign out_enable_out = oe_r;
	assign count_out = cnt;

	wire [15:0] unused_prio = {prio_r, rd_snap_r[7:0]};
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			rd_snap_r <= 16'h0000;
		else if (clk_en_in && rd_t3)
			rd_snap_r <= gra_r;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			match_a_prev_r <= 1'b0;
			match_b_prev_r <= 1'b0;
		end else if (clk_en_in) begin
			match_a_prev_r <= match_a;
			match_b_prev_r <= match_b;
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	clear_beats_write_a: assert property (clk_en_in && clear && wr_cnt |=>
		cnt == COUNT_RST) else $error("write not discarded");
	write_beats_inc_a: assert property (clk_en_in && wr_cnt && !clear |=>
		cnt == $past(wr_val)) else $error("write lost");
	gr_write_match_a: assert property (wr_gra |-> !match_a)
		else $error("match not suppressed");
	wrap_sets_flag_a: assert property (clk_en_in && wrap |=> stat_r[ST_WRAP])
		else $error("wrap flag not set");
	capture_wins_a: assert property (clk_en_in && cap_ok |=>
		gra_r == $past(cnt)) else $error("capture lost");
	pwm_no_capture_a: assert property (pwm |-> !cap_ok)
		else $error("capture in pwm");
	dual_match_a: assert property (both |-> !match_a && !match_b)
		else $error("dual match passed");
	irq_gate_a: assert property (clk_en_in |=>
		irq_out == ($past(stat_nxt[2:0]) & $past(ien_r[2:0])))
		else $error("irq gating wrong");

	// Capture-driven clear keeps the old count in the register
	capture_clear_a: assert property (clk_en_in && cap_ok &&
		clr_sel == 2'b01 |=> cnt == COUNT_RST && gra_r == $past(cnt))
		else $error("capture clear wrong");
	buf_capture_a: assert property (clk_en_in && cap_ok &&
		ctrl_r[CTRL_BUF_A] |=> bufa_r == $past(gra_r))
		else $error("buffer transfer lost");
	byte_keep_a: assert property (clk_en_in && wr_cnt && !clear &&
		pstrb_in[1:0] == 2'b01 |=> cnt[15:8] == $past(cnt[15:8]))
		else $error("unwritten byte changed");
	sync_load_a: assert property (clk_en_in && wr_cnt && !clear &&
		ctrl_r[CTRL_SYNC] |=> sync_cnt_r == $past(wr_val))
		else $error("synced counter not loaded");
	match_clear_a: assert property (clk_en_in && clr_sel == 2'b01 &&
		match_a |=> cnt == COUNT_RST)
		else $error("match clear missed");

	// A status write without a prior read of one must not clear
	flag_hold_a: assert property (clk_en_in && stat_r[ST_WRAP] &&
		!seen_r[ST_WRAP] && wr_t3 && hit(paddr_in, ADDR_STATUS) |=>
		stat_r[ST_WRAP]) else $error("flag cleared unseen");

	// Ready is a single-cycle pulse; an error only rides on it
	ready_pulse_a: assert property (clk_en_in && pready_out |=>
		!pready_out) else $error("ready held too long");
	err_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");

	cov_write: cover property (wr_cnt ##1 wr_gra);
	cov_capture: cover property (cap_ok && inc);
	cov_wrap: cover property (wrap);
	cov_byte_write: cover property (byte_acc && t2 && tick_in);
	cov_dual_match: cover property (both);
endmodule

// >>> verif/apb_cpu_model.sv
`timescale 1ns/1ns
module apb_cpu_model (
	input  wire logic        core_clk_in,
	input  wire logic        pready_in,
	input  wire logic        pslverr_in,
	input  wire logic [31:0] prdata_in,
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic [7:0]       paddr_out,
	output logic [31:0]      pwdata_out,
	output logic [3:0]       pstrb_out
);
	initial begin
		psel_out    = 1'b0;
		penable_out = 1'b0;
		pwrite_out  = 1'b0;
		paddr_out   = 8'h00;
		pwdata_out  = 32'h0;
		pstrb_out   = 4'h0;
	end

	// Call right after a rising edge; returns right after the edge following completion
	// so that a following call never lands in the same time step
	task automatic xfer(input logic wr, input logic [7:0] addr,
		input logic [31:0] data, input logic [3:0] strb,
		output logic [31:0] rdata, output logic err);
		psel_out    <= 1'b1;
		pwrite_out  <= wr;
		paddr_out   <= addr;
		pwdata_out  <= data;
		pstrb_out   <= strb;
		@(posedge core_clk_in);
		penable_out <= 1'b1;
		// No cycle count assumed: only the bench timeout ends a wait
		do begin
			@(posedge core_clk_in);
		end while (pready_in !== 1'b1);
		rdata = prdata_in;
		err   = pslverr_in;
		psel_out    <= 1'b0;
		penable_out <= 1'b0;
		// Released lines must not keep looking valid
		paddr_out   <= ~addr;
		pwdata_out  <= ~data;
		@(posedge core_clk_in);
	endtask
endmodule

// >>> verif/timer_channel_contention_logic_tb.sv
`timescale 1ns/1ns
module timer_channel_contention_logic_tb import tmr_pkg::*; ();
	logic        clk, rst, tick, cap, psel, penable, pwrite;
	logic        pready, pslverr, oe, err_seen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [2:0]  irq;
	logic [15:0] cnt;
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;

	initial clk = 1'b0;
	always #20 clk = ~clk;

	timer_channel_contention_logic dut_u (
		.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
		.tick_in(tick), .capture_in(cap), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
		.out_enable_out(oe), .count_out(cnt));

	apb_cpu_model cpu_u (
		.core_clk_in(clk), .pready_in(pready), .pslverr_in(pslverr),
		.prdata_in(prdata), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
		.pstrb_out(pstrb));

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors = errors + 1;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		cpu_u.xfer(1'b1, a, d, s, rd, err_seen);
	endtask

	task automatic rdc(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		cpu_u.xfer(1'b0, a, 32'h0, 4'h0, rd, err_seen);
		chk(what, exp, rd);
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulse_cap();
		cap <= 1'b1;
		@(posedge clk);
		cap <= 1'b0;
		@(posedge clk);
	endtask

	// Lands the capture on the completing edge of a transfer begun now:
	// setup, first, second state, then the edge that ends the third
	task automatic cap_at_t3();
		repeat (3) @(posedge clk);
		pulse_cap();
	endtask

	task automatic t_write_flags();
		tick <= 1'b1;
		wr(ADDR_CTRL, 32'h1 << CTRL_RUN);
		wr(ADDR_COUNT, 32'h1234);
		@(negedge clk);
		chk("count word", 32'h1235, {16'h0, cnt});
		@(posedge clk);
		wr(ADDR_COUNT, 32'hAB, 4'h1);
		@(negedge clk);
		chk("count byte", 32'h12AC, {16'h0, cnt});
		@(posedge clk);
		wr(ADDR_IRQ_EN, 32'h1 << ST_WRAP);
		wr(ADDR_COUNT, 32'hFFFF);
		wr(ADDR_CTRL, 32'h0);
		tick <= 1'b0;
		wr(ADDR_STATUS, 32'h0);
		chk("wrap irq", 32'h1 << ST_WRAP, {29'h0, irq});
		rdc("flags set", ADDR_STATUS, 32'h7);
		wr(ADDR_STATUS, 32'h0);
		rdc("flags clr", ADDR_STATUS, 32'h0);
		chk("irq clr", 32'h0, {29'h0, irq});
		$display("test write_flags done");
	endtask

	task automatic t_capture();
		wr(ADDR_COUNT, 32'h42);
		wr(ADDR_CTRL, 32'h1 << CTRL_CAP_A);
		pulse_cap();
		wr(ADDR_COUNT, 32'h55);
		fork
			rdc("read vs cap", ADDR_GRA, 32'h42);
			cap_at_t3();
		join
		fork
			wr(ADDR_GRA, 32'h7777);
			cap_at_t3();
		join
		rdc("write vs cap", ADDR_GRA, 32'h55);
		chk("oe normal", 32'h1, {31'h0, oe});
		wr(ADDR_CTRL, (32'h1 << CTRL_CAP_A) | (32'h1 << CTRL_PWM));
		wr(ADDR_COUNT, 32'h66);
		pulse_cap();
		rdc("pwm no cap", ADDR_GRA, 32'h55);
		// Counter stopped and coming from PWM mode
		wr(ADDR_CTRL, (32'h1 << CTRL_CAP_A) | (32'h1 << CTRL_PAIR_HI));
		pulse_cap();
		chk("oe paired", 32'h0, {31'h0, oe});
		$display("test capture done");
	endtask

	task automatic t_sync();
		do_reset();
		wr(ADDR_CTRL, 32'h1 << CTRL_SYNC);
		wr(ADDR_COUNT, 32'h3478);
		wr(ADDR_COUNT, 32'h5600, 4'h2);
		rdc("synced", ADDR_SYNC_CNT, 32'h5678);
		cpu_u.xfer(1'b0, 8'h24, 32'h0, 4'h0, rd, err_seen);
		chk("unmapped", 32'h1, {31'h0, err_seen});
		$display("test sync done");
	endtask

	task automatic t_period();
		int n;
		do_reset();
		tick <= 1'b1;
		wr(ADDR_GRA, 32'h5);
		wr(ADDR_CTRL, (32'h1 << CTRL_RUN) | (32'h1 << CTRL_CLR_LO));
		n = 0;
		while (cnt !== 16'h0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cnt !== 16'h0 && n < 20);
		chk("period", 32'h6, 32'(n));
		$display("test period done");
	endtask

	initial begin
		rst = 1'b1;
		tick = 1'b0;
		cap = 1'b0;
		do_reset();
		rdc("gra reset", ADDR_GRA, {16'h0, GR_RST});
		t_write_flags();
		t_capture();
		t_sync();
		t_period();
		summarize();
	end
endmodule
